// file: swsc_consts.svh
// Constants of the single-wire sensor command layer: codes, scratchpad
// layout, reset values and timing. Included by the command layer module.
`ifndef SWSC_CONSTS_SVH
`define SWSC_CONSTS_SVH

// ********************************************************************
// ROM-level command codes
// ********************************************************************
`define SWSC_CMD_SEARCH   8'hf0
`define SWSC_CMD_ID_READ  8'h33
`define SWSC_CMD_ID_MATCH 8'h55
`define SWSC_CMD_ID_SKIP  8'hcc

// ********************************************************************
// Function command codes
// ********************************************************************
`define SWSC_CMD_CONVERT  8'h44
`define SWSC_CMD_SP_WRITE 8'h4e
`define SWSC_CMD_SP_READ  8'hbe
`define SWSC_CMD_LOC_DET  8'h88
`define SWSC_CMD_LOC_SEL  8'h70

// ********************************************************************
// Scratchpad byte positions and fields
// ********************************************************************
`define SWSC_SP_TEMP_LO   3'h0
`define SWSC_SP_TEMP_HI   3'h1
`define SWSC_SP_STATUS    3'h2
`define SWSC_SP_CONFIG    3'h3
`define SWSC_SP_WR_FIRST  3'h3
`define SWSC_CFG_RATE_MSB 2
`define SWSC_LOC_BITS     6

// ********************************************************************
// Reset values (thresholds in sixteenths of a degree)
// ********************************************************************
`define SWSC_RST_CONFIG   8'h60
`define SWSC_RST_TH_LO    8'h00
`define SWSC_RST_TH_HI    8'h0a
`define SWSC_RST_TL_LO    8'hf0
`define SWSC_RST_TL_HI    8'hfb

// ********************************************************************
// Timing
// ********************************************************************
`define SWSC_CLK_MHZ      20
`define SWSC_CONV_TIME_US 35000
`define SWSC_AUTO_GAP_US  1000000

`endif

// file: swsc_pkg.sv
// Types shared by the sensor command layer modules.
// Assumes swsc_consts.svh sits in the include path.
package swsc_pkg;

  // Command decoder states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE   = 10'b00_0000_0001,
    ST_ROM    = 10'b00_0000_0010,
    ST_SEARCH = 10'b00_0000_0100,
    ST_IDRD   = 10'b00_0000_1000,
    ST_MATCH  = 10'b00_0001_0000,
    ST_FUNC   = 10'b00_0010_0000,
    ST_LOCSEL = 10'b00_0100_0000,
    ST_SPRD   = 10'b00_1000_0000,
    ST_SPWR   = 10'b01_0000_0000,
    ST_POLL   = 10'b10_0000_0000
  } swsc_state_t;

  typedef logic [7:0] swsc_byte_t;

endpackage

// file: swsc_crc_if.sv
// Carrier between the command decoder and its CRC engine.
// Both ends run on the same sys_clk.
`timescale 1ns/1ps
interface swsc_crc_if;
  logic       clr;
  logic       shift;
  logic       din;
  logic [7:0] crc;

  modport user   (output clr, output shift, output din, input crc);
  modport engine (input clr, input shift, input din, output crc);
endinterface

// file: swsc_crc8.sv
// Serial CRC-8 engine, x^8 + x^5 + x^4 + 1, data fed lsb first.
// Assumes one shift per transmitted bit; clr wins over shift.
`timescale 1ns/1ps
module swsc_crc8 (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Feed and result
  swsc_crc_if.engine crc_io
);

  logic [7:0] crc_r;
  logic       fb;

  // Reflected form of the polynomial: feedback taps at bits 7, 3, 2
  assign fb = crc_r[0] ^ crc_io.din;

  // Shift register starts at zero for every frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crc_r <= 8'h00;
    end else if (crc_io.clr) begin
      crc_r <= 8'h00;
    end else if (crc_io.shift) begin
      crc_r <= {fb, crc_r[7:5], crc_r[4] ^ fb, crc_r[3] ^ fb, crc_r[2:1]};
    end
  end

  assign crc_io.crc = crc_r;

endmodule

// file: swsc_cmd_layer.sv
// Command layer of a single-wire temperature sensor slave: ROM and
// function command decoding, scratchpad, conversion control.
// Assumes a bit-slot layer on sys_clk that delivers reset, write-slot and
// read-slot strobes, and samples tx_bit when it answers a read slot.
//
// Operation
// - Each transaction starts with master reset, device answers presence.
// - Exactly three 8-bit ROM commands act on the 64-bit identity: F0h, 33h, 55h.
// - Search is F0h; afterwards device waits for a new reset.
// - Identity read 33h sends the 64-bit identity code.
// - Identity match 55h: exact match addresses device, else wait reset.
// - Identity skip CCh addresses device without identity bits.
// - Convert 44h runs one conversion, stores 2-byte temperature, idles.
// - Read slots after convert return 0 while busy, 1 when done.
// - In automatic mode a convert during a conversion is ignored.
// - After commanded conversion return to the previous conversion mode.
// - Write 4Eh: five bytes go into scratchpad bytes 3 to 7.
// - Read BEh: bytes 0 onward, lsb first, through ninth CRC byte.
// - A reset during scratchpad read abandons it and reinitialises.
// - CRC built on the fly over bytes 0 to 7, sent as byte 8.
// - Location detect 88h writes location bits into status.
// - Location select 70h: only matching device answers next function.
// - Two strap inputs set the six low location bits in status.
// - Codes and data travel least significant bit first.
// - CRC polynomial x^8 + x^5 + x^4 + 1, register starts at zero.
// - Missing or misordered steps leave the device silent.
`timescale 1ns/1ps
`include "swsc_consts.svh"
module swsc_cmd_layer import swsc_pkg::*; #(
  parameter logic [63:0] ROM_ID   = 64'h5a3c_1e0f_7766_0128, // Arbitrary value
  parameter int          CONV_CYC = `SWSC_CONV_TIME_US * `SWSC_CLK_MHZ,
  parameter int          AUTO_CYC = `SWSC_AUTO_GAP_US * `SWSC_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Bit-slot layer strobes
  input  wire logic        bus_reset,
  input  wire logic        wr_slot,
  input  wire logic        wr_bit,
  input  wire logic        rd_slot,
  // Answer bits to the bit-slot layer
  output logic             tx_bit,
  output logic             presence,
  // Analog front end
  input  wire logic [15:0] temp_sample,
  input  wire logic [2:0]  location_strap_pin_a,
  input  wire logic [2:0]  location_strap_pin_b,
  output logic             conv_start,
  output logic             conv_active
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  localparam int CW = $clog2(CONV_CYC + AUTO_CYC + 1);

  swsc_state_t st_r;
  logic [6:0]  cnt_r;
  logic [1:0]  phase_r;
  logic        mism_r;
  logic        loc_only_r;
  swsc_byte_t  rx_r;
  swsc_byte_t  sp_r [0:7];
  logic        tx_bit_r;
  logic        tx_nxt;
  logic        presence_r;
  logic        conv_busy_r;
  logic        conv_start_r;
  logic        conv_done_r;
  logic [CW-1:0] conv_cnt_r;
  logic [CW-1:0] gap_cnt_r;
  logic [5:0]  loc_s1_r;
  logic [5:0]  loc_s2_r;
  swsc_byte_t  byte_now;
  logic        byte_done;
  logic        rom_bit;
  logic        sp_bit;
  logic        auto_on;
  logic        auto_tick;
  logic        conv_req;
  logic        det_go;
  logic [2:0]  wr_idx;

  swsc_crc_if crc_bus ();

  swsc_crc8 u_crc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .crc_io  (crc_bus.engine)
  );

  // ******************************************************************
  // Receive path and decode helpers
  // ******************************************************************
  // Incoming bits fill the byte from the top, so bit 0 arrives first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_r <= 8'h00;
    end else if (wr_slot) begin
      rx_r <= {wr_bit, rx_r[7:1]};
    end
  end

  // Byte completes on the eighth write slot of a byte frame
  assign byte_now  = {wr_bit, rx_r[7:1]};
  assign byte_done = wr_slot && (cnt_r[2:0] == 3'h7);
  assign rom_bit   = ROM_ID[cnt_r[5:0]];
  assign wr_idx    = `SWSC_SP_WR_FIRST + cnt_r[5:3];
  assign sp_bit    = cnt_r[6] ? crc_bus.crc[cnt_r[2:0]]
                              : sp_r[cnt_r[5:3]][cnt_r[2:0]];
  assign det_go    = byte_done && (byte_now == `SWSC_CMD_LOC_DET) &&
                     (st_r == ST_ROM || (st_r == ST_FUNC && !loc_only_r));
  assign conv_req  = byte_done && (byte_now == `SWSC_CMD_CONVERT) && (st_r == ST_FUNC);

  // ******************************************************************
  // Location strap synchroniser
  // ******************************************************************
  // Strap levels come from outside the clock domain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      loc_s1_r <= 6'h00;
      loc_s2_r <= 6'h00;
    end else begin
      loc_s1_r <= {location_strap_pin_b, location_strap_pin_a};
      loc_s2_r <= loc_s1_r;
    end
  end

  // ******************************************************************
  // Command sequencer
  // ******************************************************************
  // Reset pulse overrides every state; illegal codes fall back to idle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r       <= ST_IDLE;
      cnt_r      <= 7'h00;
      phase_r    <= 2'h0;
      mism_r     <= 1'b0;
      loc_only_r <= 1'b0;
    end else if (bus_reset) begin
      st_r       <= ST_ROM;
      cnt_r      <= 7'h00;
      phase_r    <= 2'h0;
      mism_r     <= 1'b0;
      loc_only_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          cnt_r <= 7'h00;
        end
        ST_ROM: begin
          if (wr_slot) begin
            cnt_r <= byte_done ? 7'h00 : cnt_r + 7'h01;
          end
          if (byte_done) begin
            unique case (byte_now)
              `SWSC_CMD_SEARCH:   st_r <= ST_SEARCH;
              `SWSC_CMD_ID_READ:  st_r <= ST_IDRD;
              `SWSC_CMD_ID_MATCH: st_r <= ST_MATCH;
              `SWSC_CMD_ID_SKIP:  st_r <= ST_FUNC;
              `SWSC_CMD_LOC_SEL:  st_r <= ST_LOCSEL;
              default:            st_r <= ST_IDLE;
            endcase
          end
        end
        ST_SEARCH: begin
          if (rd_slot && phase_r != 2'h2) begin
            phase_r <= phase_r + 2'h1;
          end else if (wr_slot && phase_r == 2'h2) begin
            phase_r <= 2'h0;
            cnt_r   <= cnt_r + 7'h01;
            if (wr_bit != rom_bit || cnt_r == 7'd63) begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_IDRD: begin
          if (rd_slot) begin
            cnt_r <= (cnt_r == 7'd63) ? 7'h00 : cnt_r + 7'h01;
            if (cnt_r == 7'd63) begin
              st_r <= ST_FUNC;
            end
          end
        end
        ST_MATCH: begin
          if (wr_slot) begin
            mism_r <= mism_r | (wr_bit != rom_bit);
            cnt_r  <= (cnt_r == 7'd63) ? 7'h00 : cnt_r + 7'h01;
            if (cnt_r == 7'd63) begin
              st_r <= (mism_r || wr_bit != rom_bit) ? ST_IDLE : ST_FUNC;
            end
          end
        end
        ST_FUNC: begin
          if (wr_slot) begin
            cnt_r <= byte_done ? 7'h00 : cnt_r + 7'h01;
          end
          if (byte_done) begin
            unique case (byte_now)
              `SWSC_CMD_CONVERT:  st_r <= ST_POLL;
              `SWSC_CMD_SP_READ:  st_r <= ST_SPRD;
              `SWSC_CMD_SP_WRITE: st_r <= ST_SPWR;
              `SWSC_CMD_LOC_SEL:  st_r <= loc_only_r ? ST_IDLE : ST_LOCSEL;
              default:            st_r <= ST_IDLE;
            endcase
          end
        end
        ST_LOCSEL: begin
          if (wr_slot) begin
            cnt_r <= byte_done ? 7'h00 : cnt_r + 7'h01;
          end
          // Top two status bits are never written and stay zero; only six are compared
          if (byte_done) begin
            if (byte_now[5:0] == sp_r[`SWSC_SP_STATUS][5:0]) begin
              st_r       <= ST_FUNC;
              loc_only_r <= 1'b1;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_SPRD: begin
          if (rd_slot) begin
            cnt_r <= cnt_r + 7'h01;
            if (cnt_r == 7'd71) begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_SPWR: begin
          if (wr_slot) begin
            cnt_r <= cnt_r + 7'h01;
            if (cnt_r == 7'd39) begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_POLL: begin
          cnt_r <= 7'h00;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ******************************************************************
  // Transmit bit and presence
  // ******************************************************************
  // Released line (1) whenever the device has nothing to say
  always_comb begin
    tx_nxt = 1'b1;
    unique case (st_r)
      ST_SEARCH: tx_nxt = (phase_r == 2'h1) ? ~rom_bit
                        : (phase_r == 2'h0) ? rom_bit : 1'b1;
      ST_IDRD:   tx_nxt = rom_bit;
      ST_SPRD:   tx_nxt = sp_bit;
      ST_POLL:   tx_nxt = ~conv_busy_r;
      default:   tx_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_bit_r   <= 1'b1;
      presence_r <= 1'b0;
    end else begin
      tx_bit_r   <= tx_nxt;
      presence_r <= bus_reset;
    end
  end

  // CRC clears on the read command and follows the first 64 bits sent
  assign crc_bus.clr   = byte_done && (byte_now == `SWSC_CMD_SP_READ) && (st_r == ST_FUNC);
  assign crc_bus.shift = rd_slot && (st_r == ST_SPRD) && !cnt_r[6];
  assign crc_bus.din   = sp_bit;

  // ******************************************************************
  // Conversion control
  // ******************************************************************
  // Automatic mode follows the rate field, so a one-shot never alters it
  assign auto_on   = sp_r[`SWSC_SP_CONFIG][`SWSC_CFG_RATE_MSB:0] != 3'h0;
  assign auto_tick = auto_on && !conv_busy_r && (gap_cnt_r == '0);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_busy_r  <= 1'b0;
      conv_start_r <= 1'b0;
      conv_done_r  <= 1'b0;
      conv_cnt_r   <= '0;
    end else begin
      conv_start_r <= 1'b0;
      conv_done_r  <= 1'b0;
      if (conv_busy_r) begin
        // A start arriving now is dropped: one conversion at a time
        if (conv_cnt_r == '0) begin
          conv_busy_r <= 1'b0;
          conv_done_r <= 1'b1;
        end else begin
          conv_cnt_r <= conv_cnt_r - 1'b1;
        end
      end else if (conv_req || auto_tick) begin
        conv_busy_r  <= 1'b1;
        conv_start_r <= 1'b1;
        conv_cnt_r   <= CW'(CONV_CYC - 1);
      end
    end
  end

  // Gap timer between automatic conversions
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_cnt_r <= '0;
    end else if (!auto_on || conv_busy_r) begin
      gap_cnt_r <= CW'(AUTO_CYC - 1);
    end else if (gap_cnt_r != '0) begin
      gap_cnt_r <= gap_cnt_r - 1'b1;
    end
  end

  // ******************************************************************
  // Scratchpad
  // ******************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sp_r[0] <= 8'h00;
      sp_r[1] <= 8'h00;
      sp_r[2] <= 8'h00;
      sp_r[3] <= `SWSC_RST_CONFIG;
      sp_r[4] <= `SWSC_RST_TH_LO;
      sp_r[5] <= `SWSC_RST_TH_HI;
      sp_r[6] <= `SWSC_RST_TL_LO;
      sp_r[7] <= `SWSC_RST_TL_HI;
    end else begin
      if (conv_done_r) begin
        sp_r[`SWSC_SP_TEMP_LO] <= temp_sample[7:0];
        sp_r[`SWSC_SP_TEMP_HI] <= temp_sample[15:8];
      end
      if (det_go) begin
        sp_r[`SWSC_SP_STATUS][5:0] <= loc_s2_r;
      end
      if (st_r == ST_SPWR && byte_done && !bus_reset) begin
        sp_r[wr_idx] <= byte_now;
      end
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign tx_bit      = tx_bit_r;
  assign presence    = presence_r;
  assign conv_start  = conv_start_r;
  assign conv_active = conv_busy_r;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_reset_abort: assert property (bus_reset |=> st_r == ST_ROM && presence_r)
    else $error("reset pulse did not restart command decoding");

  a_skip_addr: assert property (st_r == ST_ROM && byte_done && !bus_reset &&
      byte_now == `SWSC_CMD_ID_SKIP |=> st_r == ST_FUNC)
    else $error("skip did not address the device");

  a_search_drop: assert property (st_r == ST_SEARCH && phase_r == 2'h2 && wr_slot &&
      !bus_reset && wr_bit != rom_bit |=> st_r == ST_IDLE ##1 st_r == ST_IDLE)
    else $error("search did not drop out on mismatch");

  a_match_fail: assert property (st_r == ST_MATCH && wr_slot && !bus_reset &&
      cnt_r == 7'd63 && (mism_r || wr_bit != rom_bit) |=> st_r == ST_IDLE)
    else $error("mismatched identity was still addressed");

  a_id_read_bit: assert property (st_r == ST_IDRD && $past(st_r) == ST_IDRD &&
      $stable(cnt_r) |-> tx_bit_r == ROM_ID[cnt_r[5:0]])
    else $error("identity bit on the line is wrong");

  a_poll_status: assert property (st_r == ST_POLL && $past(st_r) == ST_POLL |->
      tx_bit_r == !$past(conv_busy_r))
    else $error("conversion status bit is wrong");

  a_busy_ignore: assert property (conv_busy_r && conv_cnt_r != '0 && conv_req |=>
      conv_cnt_r == $past(conv_cnt_r) - 1'b1 && !conv_start_r)
    else $error("convert during a conversion restarted it");

  a_write_store: assert property (st_r == ST_SPWR && byte_done && !bus_reset |=>
      sp_r[$past(wr_idx)] == $past(byte_now))
    else $error("scratchpad write byte not stored");

  a_crc_byte: assert property (st_r == ST_SPRD && $past(st_r) == ST_SPRD &&
      $stable(cnt_r) && cnt_r >= 7'd64 |-> tx_bit_r == crc_bus.crc[cnt_r[2:0]])
    else $error("crc byte bit on the line is wrong");

  a_loc_select: assert property (st_r == ST_LOCSEL && byte_done && !bus_reset &&
      byte_now[5:0] != sp_r[`SWSC_SP_STATUS][5:0] |=> st_r == ST_IDLE)
    else $error("wrong location was selected");

endmodule

// file: swsc_mst.sv
// Behavioural single-wire bus master driving the slot strobes.
// Assumes sys_clk is shared; caller orders the transaction steps.
`timescale 1ns/1ps
module swsc_mst (
  // Clock and device answers
  input  wire logic sys_clk,
  input  wire logic tx_bit,
  input  wire logic presence,
  input  wire logic conv_active,
  // Slot strobes
  output logic      bus_reset,
  output logic      wr_slot,
  output logic      wr_bit,
  output logic      rd_slot
);
  // ************************************************************
  // Strobe tasks
  // ************************************************************
  logic strong_pullup;

  // Strong pullup follows the conversion one cycle late, well inside 10 us
  always @(posedge sys_clk) strong_pullup <= conv_active;

  initial begin
    bus_reset = 1'b0;
    wr_slot   = 1'b0;
    wr_bit    = 1'b0;
    rd_slot   = 1'b0;
  end

  // Reset pulse, may cut any transfer short; presence sampled after
  task automatic init(output logic seen);
    @(posedge sys_clk);
    bus_reset <= 1'b1;
    @(posedge sys_clk);
    bus_reset <= 1'b0;
    @(posedge sys_clk);
    seen = presence;
    @(posedge sys_clk);
  endtask

  // One slot; three idle cycles so tx_bit settles before the next
  task automatic slot(input logic rd, input logic b, output logic q);
    @(posedge sys_clk);
    rd_slot <= rd;
    wr_slot <= ~rd;
    wr_bit  <= b;
    @(posedge sys_clk);
    q = tx_bit;
    rd_slot <= 1'b0;
    wr_slot <= 1'b0;
    wr_bit  <= ~b; // Released line never keeps the last bit
    repeat (3) @(posedge sys_clk);
  endtask

  // Whole bytes, lsb first; caller keeps ROM step before function step
  task automatic send_byte(input logic [7:0] v);
    logic q;
    for (int i = 0; i < 8; i++) slot(1'b0, v[i], q);
  endtask

  // Read n bits lsb first into v
  task automatic read_bits(input int n, output logic [71:0] v);
    v = '0;
    for (int i = 0; i < n; i++) slot(1'b1, 1'b1, v[i]);
  endtask
endmodule

// file: swsc_cmd_layer_tb.sv
// Self-checking bench of the sensor command layer.
// Assumes the master model stands in for the bit-slot layer.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module swsc_cmd_layer_tb;
  localparam logic [63:0] ID  = 64'h1c2b_3a49_5867_7685; // Arbitrary value
  localparam logic [63:0] SP0 = 64'hfbf0_0a00_6000_0000;
  localparam logic [39:0] WR  = 40'hd4c3_b2a1_68;
  localparam logic [15:0] TMP = 16'h0191;
  logic        sys_clk, rst, bus_reset, wr_slot, wr_bit, rd_slot;
  logic        tx_bit, presence, conv_start, conv_active;
  logic [2:0]  pin_a, pin_b;
  logic [71:0] v;
  int          miscompares, n_compared, n_conv;

  // ************************************************************
  // Design, master model, clock
  // ************************************************************
  swsc_cmd_layer #(.ROM_ID(ID), .CONV_CYC(200), .AUTO_CYC(50)) swsc_cmd_layer_i (
    .sys_clk(sys_clk), .rst(rst), .bus_reset(bus_reset), .wr_slot(wr_slot),
    .wr_bit(wr_bit), .rd_slot(rd_slot), .tx_bit(tx_bit), .presence(presence),
    .temp_sample(TMP), .location_strap_pin_a(pin_a), .location_strap_pin_b(pin_b),
    .conv_start(conv_start), .conv_active(conv_active));
  swsc_mst swsc_mst_i (.sys_clk(sys_clk), .tx_bit(tx_bit), .presence(presence),
    .conv_active(conv_active),
    .bus_reset(bus_reset), .wr_slot(wr_slot), .wr_bit(wr_bit), .rd_slot(rd_slot));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Count conversions; pulses are too short to catch inside tasks
  always @(posedge sys_clk) if (conv_start === 1'b1) n_conv++;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction
  task automatic ini();
    logic p;
    swsc_mst_i.init(p);
    `CHK(p, 1'b1)
  endtask
  task automatic sb(input logic [7:0] b);
    swsc_mst_i.send_byte(b);
  endtask
  task automatic sid(input logic [63:0] x);
    for (int i = 0; i < 8; i++) sb(x[8*i+:8]);
  endtask
  task automatic cwait();
    int k;
    k = 0;
    while (conv_active !== 1'b0 && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 300) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_idle();
    `CHK(tx_bit, 1'b1)
    sb(8'h44);
    `CHK(n_conv, 0)
  endtask
  task automatic t_id();
    ini();
    sb(8'h33);
    swsc_mst_i.read_bits(64, v);
    `CHK(v[63:0], ID)
  endtask
  task automatic t_crc();
    ini();
    sb(8'hcc);
    sb(8'hbe);
    swsc_mst_i.read_bits(72, v);
    `CHK(v[63:0], SP0)
    `CHK(v[71:64], crc8(SP0))
  endtask
  task automatic t_abort();
    int n0;
    n0 = n_conv;
    ini();
    sb(8'hcc);
    sb(8'hbe);
    swsc_mst_i.read_bits(10, v);
    ini();
    sb(8'h44);
    `CHK(n_conv, n0)
  endtask
  task automatic t_wr();
    ini();
    sb(8'hcc);
    sb(8'h4e);
    for (int i = 0; i < 5; i++) sb(WR[8*i+:8]);
    ini();
    sb(8'hcc);
    sb(8'hbe);
    swsc_mst_i.read_bits(72, v);
    `CHK(v[63:0], {WR, SP0[23:0]})
    `CHK(v[71:64], crc8({WR, SP0[23:0]}))
  endtask
  task automatic t_search();
    logic [63:0] b, c;
    logic        q;
    int          n0;
    n0 = n_conv;
    ini();
    sb(8'hf0);
    for (int i = 0; i < 64; i++) begin
      swsc_mst_i.slot(1'b1, 1'b1, b[i]);
      swsc_mst_i.slot(1'b1, 1'b1, c[i]);
      swsc_mst_i.slot(1'b0, b[i], q);
    end
    `CHK(b, ID)
    `CHK(c, ~ID)
    sb(8'h44);
    `CHK(n_conv, n0)
    ini();
    sb(8'hf0);
    swsc_mst_i.read_bits(2, v);
    swsc_mst_i.slot(1'b0, ~ID[0], q);
    swsc_mst_i.read_bits(2, v);
    `CHK(v[1:0], 2'b11)
  endtask
  task automatic t_match();
    int n0;
    n0 = n_conv;
    ini();
    sb(8'h55);
    sid(ID ^ 64'h1);
    sb(8'h44);
    `CHK(n_conv, n0)
    ini();
    sb(8'h55);
    sid(ID);
    sb(8'h44);
    `CHK(n_conv, n0 + 1)
    cwait();
  endtask
  task automatic t_conv();
    logic q;
    int   n0;
    n0 = n_conv;
    ini();
    sb(8'hcc);
    sb(8'h44);
    swsc_mst_i.slot(1'b1, 1'b1, q);
    `CHK(q, 1'b0)
    `CHK(swsc_mst_i.strong_pullup, 1'b1)
    // Second convert lands while the first still runs and must be dropped
    ini();
    sb(8'hcc);
    sb(8'h44);
    `CHK(n_conv, n0 + 1)
    for (int k = 0; k < 80 && q !== 1'b1; k++) swsc_mst_i.slot(1'b1, 1'b1, q);
    `CHK(q, 1'b1)
    `CHK(n_conv, n0 + 1)
    `CHK(swsc_mst_i.strong_pullup, 1'b0)
    ini();
    sb(8'hcc);
    sb(8'hbe);
    swsc_mst_i.read_bits(16, v);
    `CHK(v[15:0], TMP)
  endtask
  task automatic t_loc();
    int n0;
    ini();
    sb(8'h88);
    ini();
    sb(8'h70);
    sb(8'h15);
    sb(8'hbe);
    swsc_mst_i.read_bits(24, v);
    `CHK(v[21:16], 6'h15)
    n0 = n_conv;
    ini();
    sb(8'h70);
    sb(8'h16);
    sb(8'h44);
    `CHK(n_conv, n0)
    ini();
    sb(8'h70);
    sb(8'h15);
    sb(8'h44);
    `CHK(n_conv, n0 + 1)
    cwait();
  endtask

  initial begin
    rst = 1'b1;
    pin_a = 3'h5;
    pin_b = 3'h2;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_idle();
    t_id();
    t_crc();
    t_abort();
    t_wr();
    t_search();
    t_match();
    t_conv();
    t_loc();
    end_of_test();
  end
endmodule
